// *** src/flash_cmd_map.vh ***
// Opcodes, frame bit counts, status layout and default cycle counts of the flash command block.
`ifndef FLASH_CMD_MAP_VH
`define FLASH_CMD_MAP_VH

// Command opcodes.
`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_READ_STATUS 8'h05
`define OP_DUAL_READ 8'h3B
`define OP_PAGE_WRITE 8'h02
`define OP_SECTOR_CLEAR 8'h20
`define OP_HALF_BLOCK_CLEAR 8'h52
`define OP_FULL_BLOCK_CLEAR 8'hD8
`define OP_CHIP_CLEAR_A 8'h60
`define OP_CHIP_CLEAR_B 8'hC7
`define OP_ID_READ 8'h90

// Rising edge counts that close each part of a frame.
`define BITS_OPCODE 6'h08
`define BITS_ADDR_END 6'h20
`define BITS_HEADER 6'h28

// Status byte bit positions.
`define STAT_WIP 0
`define STAT_WEL 1
`define STAT_BP_LSB 2

// Clear extent codes on the array erase port.
`define CLEAR_SECTOR 2'h0
`define CLEAR_HALF_BLOCK 2'h1
`define CLEAR_FULL_BLOCK 2'h2
`define CLEAR_CHIP 2'h3

// Default self-timed cycle lengths in clk cycles.
`define PROG_CYCLES_DEF 32'h00001000
`define SECTOR_CYCLES_DEF 32'h00002000
`define HALF_BLOCK_CYCLES_DEF 32'h00003000
`define FULL_BLOCK_CYCLES_DEF 32'h00004000
`define CHIP_CYCLES_DEF 32'h00008000

// Reset values.
`define RESET_OPCODE 8'h00
`define RESET_WEL 1'b0
`define RESET_WIP 1'b0

`endif

// *** src/pin_sync.v ***
// Two-stage synchroniser with edge detection for a group of pins.
module pin_sync #(
   parameter WIDTH = 3
) (
   // Clock and reset.
   input wire clk,
   input wire rst,
   // Pins from outside the clock domain.
   input wire [WIDTH-1:0] pin_async,
   // Synchronised level and one-cycle edge pulses.
   output wire [WIDTH-1:0] level,
   output wire [WIDTH-1:0] rise,
   output wire [WIDTH-1:0] fall
);
   genvar g;
   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : stage
         reg meta_reg;
         reg sync_reg;
         reg prev_reg;
         // The first flop feeds only the second; edges come from later stages.
         always @(posedge clk or posedge rst) begin
            if (rst) begin
               meta_reg <= 1'b0;
               sync_reg <= 1'b0;
               prev_reg <= 1'b0;
            end else begin
               meta_reg <= pin_async[g];
               sync_reg <= meta_reg;
               prev_reg <= sync_reg;
            end
         end
         assign level[g] = sync_reg;
         assign rise[g] = sync_reg & ~prev_reg;
         assign fall[g] = ~sync_reg & prev_reg;
      end
   endgenerate
endmodule

// *** src/flash_cmd_engine.v ***
// Serial flash command decoder with dual read, page write, clears and id read.
//
// Contract
// - Dual read: opcode, three address bytes, dummy byte, then two bits per clock.
// - Reads start anywhere and the address advances after each byte.
// - Page write and every clear need the write enable latch set.
// - Data past the page end wraps to the page's first byte.
// - Over 256 data bytes: only the final 256 are written.
// - Under 256 data bytes: other bytes of the page stay unchanged.
// - Page write runs only if select rises on a whole data byte.
// - Select rise starts the timed cycle; busy set, latch cleared before done.
// - Status reads still answer during a timed cycle.
// - Page write to a protected page is not executed.
// - Sector clear takes any address inside the sector.
// - Sector and block clears need select rising right after the address.
// - Sector clear to a protected sector is not executed.
// - Half block clear erases the whole 32 KB block addressed.
// - Full block clear erases the whole 64 KB block addressed.
// - Block clears to a protected block are not executed.
// - Chip clear takes either opcode; select must rise after the opcode.
// - Chip clear runs only with no block protected: bits all off, or all on with complement.
// - Id read returns maker byte then device byte, MSB first.
// - Write enable opcode alone in a frame sets the latch unless a timed cycle runs.
// - Status opcode returns the status byte with busy and latch flags.
// - Dual read puts odd bits on line one and even bits on line zero.
`include "flash_cmd_map.vh"

module flash_cmd_engine #(
   parameter [7:0] MAKER_ID = 8'hA5,
   parameter [7:0] DEVICE_ID = 8'h5A,
   parameter [31:0] PROG_CYCLES = `PROG_CYCLES_DEF,
   parameter [31:0] SECTOR_CYCLES = `SECTOR_CYCLES_DEF,
   parameter [31:0] HALF_BLOCK_CYCLES = `HALF_BLOCK_CYCLES_DEF,
   parameter [31:0] FULL_BLOCK_CYCLES = `FULL_BLOCK_CYCLES_DEF,
   parameter [31:0] CHIP_CYCLES = `CHIP_CYCLES_DEF
) (
   // Clock and reset.
   input wire clk,
   input wire rst,
   // Serial pins from the host.
   input wire chip_select_n,
   input wire serial_clock,
   input wire io0_in,
   output reg io0_out,
   output reg io0_oe,
   output reg io1_out,
   output reg io1_oe,
   // Protection setting.
   input wire [2:0] block_protect,
   input wire protect_complement,
   // Status flags.
   output reg write_in_progress,
   output reg write_enable_latch,
   // Array read port, data valid one clk after the address.
   output reg [19:0] mem_rd_addr,
   input wire [7:0] mem_rd_data,
   // Array byte write port.
   output reg mem_wr_en,
   output reg [19:0] mem_wr_addr,
   output reg [7:0] mem_wr_data,
   // Array clear port.
   output reg mem_clear_en,
   output reg [19:0] mem_clear_addr,
   output reg [1:0] mem_clear_kind
);
   // One-hot engine states.
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_WRITE = 3'b010;
   localparam [2:0] ST_WAIT = 3'b100;

   wire [2:0] lvl;
   wire [2:0] rise;
   wire [2:0] fall;

   // Pins pass two flops; select goes in inverted so reset reads as deselected, no false edge.
   pin_sync #(.WIDTH(3)) sync_u (
      .clk(clk),
      .rst(rst),
      .pin_async({io0_in, serial_clock, ~chip_select_n}),
      .level(lvl),
      .rise(rise),
      .fall(fall)
   );

   wire selected = lvl[0];
   wire sclk_rise = rise[1] & selected;
   wire sclk_fall = fall[1] & selected;
   wire si = lvl[2];
   wire frame_start = rise[0];
   wire frame_end = fall[0];

   reg [7:0] opcode_reg;
   reg [5:0] hdr_cnt_reg;
   reg [2:0] bitpos_reg;
   reg [7:0] shift_in_reg;
   reg [23:0] addr_reg;
   reg [7:0] wr_idx_reg;
   reg [255:0] mask_reg;
   reg [7:0] page_buf [0:255];
   reg [7:0] shift_out_reg;
   reg [2:0] out_cnt_reg;
   reg id_sel_reg;
   reg [2:0] state_reg;
   reg [7:0] eng_idx_reg;
   reg [11:0] page_reg;
   reg [31:0] timer_reg;

   // Protection test for a 64 KB block index; upper blocks are guarded first.
   function prot_hit;
      input [3:0] blk;
      input [2:0] bp;
      input cmp;
      reg hit;
      begin
         case (bp)
            3'h0: hit = 1'b0;
            3'h1: hit = (blk == 4'hF);
            3'h2: hit = (blk >= 4'hE);
            3'h3: hit = (blk >= 4'hC);
            3'h4: hit = (blk >= 4'h8);
            default: hit = 1'b1;
         endcase
         prot_hit = hit ^ cmp;
      end
   endfunction

   wire [7:0] status_byte = {3'h0, block_protect, write_enable_latch, write_in_progress};
   wire addr_prot = prot_hit(addr_reg[19:16], block_protect, protect_complement);
   wire chip_ok = ((block_protect == 3'h0) & ~protect_complement) |
      ((block_protect == 3'h7) & protect_complement);
   wire is_chip_op = (opcode_reg == `OP_CHIP_CLEAR_A) | (opcode_reg == `OP_CHIP_CLEAR_B);
   wire is_block_op = (opcode_reg == `OP_SECTOR_CLEAR) | (opcode_reg == `OP_HALF_BLOCK_CLEAR) |
      (opcode_reg == `OP_FULL_BLOCK_CLEAR);
   wire [7:0] in_byte = {shift_in_reg[6:0], si};
   wire capture_data = sclk_rise & ~write_in_progress & (opcode_reg == `OP_PAGE_WRITE) &
      (hdr_cnt_reg >= 6'h27) & (bitpos_reg == 3'h7);

   // Program start needs the latch, whole data bytes and an unguarded page.
   wire start_prog = frame_end & ~write_in_progress & write_enable_latch &
      (opcode_reg == `OP_PAGE_WRITE) & (hdr_cnt_reg == `BITS_HEADER) &
      (bitpos_reg == 3'h0) & ~addr_prot;
   // Clear start needs select rising right after the address or the opcode.
   wire start_block = frame_end & ~write_in_progress & write_enable_latch & is_block_op &
      (hdr_cnt_reg == `BITS_ADDR_END) & ~addr_prot;
   wire start_chip = frame_end & ~write_in_progress & write_enable_latch & is_chip_op &
      (hdr_cnt_reg == `BITS_OPCODE) & chip_ok;

   // Output phases: status always, reads only while idle.
   wire out_status = (opcode_reg == `OP_READ_STATUS) & (hdr_cnt_reg >= `BITS_OPCODE);
   wire out_id = (opcode_reg == `OP_ID_READ) & (hdr_cnt_reg >= `BITS_ADDR_END) &
      ~write_in_progress;
   wire out_dual = (opcode_reg == `OP_DUAL_READ) & (hdr_cnt_reg == `BITS_HEADER) &
      ~write_in_progress;

   // Frame input: opcode, address and bit counters on sampled rising edges.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         opcode_reg <= `RESET_OPCODE;
         hdr_cnt_reg <= 6'h00;
         bitpos_reg <= 3'h0;
         shift_in_reg <= 8'h00;
         addr_reg <= 24'h000000;
      end else if (frame_start) begin
         opcode_reg <= `RESET_OPCODE;
         hdr_cnt_reg <= 6'h00;
         bitpos_reg <= 3'h0;
      end else if (sclk_rise) begin
         shift_in_reg <= in_byte;
         bitpos_reg <= bitpos_reg + 3'h1;
         if (hdr_cnt_reg != `BITS_HEADER) begin
            hdr_cnt_reg <= hdr_cnt_reg + 6'h01;
         end
         if (hdr_cnt_reg == 6'h07) begin
            opcode_reg <= in_byte;
         end
         if ((hdr_cnt_reg >= `BITS_OPCODE) && (hdr_cnt_reg < `BITS_ADDR_END)) begin
            addr_reg <= {addr_reg[22:0], si};
         end
      end
   end

   // Page buffer bytes land at the running index; 8-bit wrap keeps them in the page.
   always @(posedge clk) begin
      if (capture_data) begin
         page_buf[wr_idx_reg] <= in_byte;
      end
   end

   // Byte index and written-byte mask for the page write.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_idx_reg <= 8'h00;
         mask_reg <= 256'h0;
      end else if (frame_start && !write_in_progress) begin
         mask_reg <= 256'h0;
      end else if (sclk_rise && (hdr_cnt_reg == 6'h1F)) begin
         wr_idx_reg <= {addr_reg[6:0], si};
      end else if (capture_data) begin
         mask_reg[wr_idx_reg] <= 1'b1;
         wr_idx_reg <= wr_idx_reg + 8'h01;
      end
   end

   // Output shifting on sampled falling edges; select high releases the lines.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         io0_out <= 1'b0;
         io0_oe <= 1'b0;
         io1_out <= 1'b0;
         io1_oe <= 1'b0;
         shift_out_reg <= 8'h00;
         out_cnt_reg <= 3'h0;
         id_sel_reg <= 1'b0;
         mem_rd_addr <= 20'h00000;
      end else if (!selected) begin
         io0_oe <= 1'b0;
         io1_oe <= 1'b0;
         out_cnt_reg <= 3'h0;
         id_sel_reg <= 1'b0;
      end else if (sclk_rise && (hdr_cnt_reg == 6'h1F)) begin
         mem_rd_addr <= {addr_reg[18:0], si};
      end else if (sclk_fall && out_dual) begin
         io0_oe <= 1'b1;
         io1_oe <= 1'b1;
         out_cnt_reg <= {1'b0, out_cnt_reg[1:0] + 2'h1};
         if (out_cnt_reg[1:0] == 2'h0) begin
            io1_out <= mem_rd_data[7];
            io0_out <= mem_rd_data[6];
            shift_out_reg <= {mem_rd_data[5:0], 2'h0};
            mem_rd_addr <= mem_rd_addr + 20'h00001;
         end else begin
            io1_out <= shift_out_reg[7];
            io0_out <= shift_out_reg[6];
            shift_out_reg <= {shift_out_reg[5:0], 2'h0};
         end
      end else if (sclk_fall && (out_status || out_id)) begin
         io1_oe <= 1'b1;
         out_cnt_reg <= out_cnt_reg + 3'h1;
         if (out_cnt_reg == 3'h0) begin
            if (out_status) begin
               io1_out <= status_byte[7];
               shift_out_reg <= {status_byte[6:0], 1'b0};
            end else begin
               io1_out <= id_sel_reg ? DEVICE_ID[7] : MAKER_ID[7];
               shift_out_reg <= id_sel_reg ? {DEVICE_ID[6:0], 1'b0} : {MAKER_ID[6:0], 1'b0};
               id_sel_reg <= ~id_sel_reg;
            end
         end else begin
            io1_out <= shift_out_reg[7];
            shift_out_reg <= {shift_out_reg[6:0], 1'b0};
         end
      end
   end

   // Self-timed engine: latch, busy flag, array write walk and cycle timer.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= ST_IDLE;
         write_in_progress <= `RESET_WIP;
         write_enable_latch <= `RESET_WEL;
         eng_idx_reg <= 8'h00;
         page_reg <= 12'h000;
         timer_reg <= 32'h00000000;
         mem_wr_en <= 1'b0;
         mem_wr_addr <= 20'h00000;
         mem_wr_data <= 8'h00;
         mem_clear_en <= 1'b0;
         mem_clear_addr <= 20'h00000;
         mem_clear_kind <= `CLEAR_SECTOR;
      end else begin
         mem_wr_en <= 1'b0;
         mem_clear_en <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               if (frame_end && (hdr_cnt_reg == `BITS_OPCODE) &&
                   (opcode_reg == `OP_WRITE_ENABLE)) begin
                  write_enable_latch <= 1'b1;
               end else if (frame_end && (hdr_cnt_reg == `BITS_OPCODE) &&
                   (opcode_reg == `OP_WRITE_DISABLE)) begin
                  write_enable_latch <= 1'b0;
               end else if (start_prog) begin
                  write_in_progress <= 1'b1;
                  write_enable_latch <= 1'b0;
                  page_reg <= addr_reg[19:8];
                  eng_idx_reg <= 8'h00;
                  timer_reg <= PROG_CYCLES;
                  state_reg <= ST_WRITE;
               end else if (start_block || start_chip) begin
                  write_in_progress <= 1'b1;
                  write_enable_latch <= 1'b0;
                  mem_clear_en <= 1'b1;
                  state_reg <= ST_WAIT;
                  if (start_chip) begin
                     mem_clear_addr <= 20'h00000;
                     mem_clear_kind <= `CLEAR_CHIP;
                     timer_reg <= CHIP_CYCLES;
                  end else if (opcode_reg == `OP_SECTOR_CLEAR) begin
                     mem_clear_addr <= {addr_reg[19:12], 12'h000};
                     mem_clear_kind <= `CLEAR_SECTOR;
                     timer_reg <= SECTOR_CYCLES;
                  end else if (opcode_reg == `OP_HALF_BLOCK_CLEAR) begin
                     mem_clear_addr <= {addr_reg[19:15], 15'h0000};
                     mem_clear_kind <= `CLEAR_HALF_BLOCK;
                     timer_reg <= HALF_BLOCK_CYCLES;
                  end else begin
                     mem_clear_addr <= {addr_reg[19:16], 16'h0000};
                     mem_clear_kind <= `CLEAR_FULL_BLOCK;
                     timer_reg <= FULL_BLOCK_CYCLES;
                  end
               end
            end
            ST_WRITE: begin
               // Only bytes that arrived are written; the rest of the page is untouched.
               mem_wr_en <= mask_reg[eng_idx_reg];
               mem_wr_addr <= {page_reg, eng_idx_reg};
               mem_wr_data <= page_buf[eng_idx_reg];
               eng_idx_reg <= eng_idx_reg + 8'h01;
               if (eng_idx_reg == 8'hFF) begin
                  state_reg <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (timer_reg <= 32'h00000001) begin
                  write_in_progress <= 1'b0;
                  state_reg <= ST_IDLE;
               end else begin
                  timer_reg <= timer_reg - 32'h00000001;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
               write_in_progress <= 1'b0;
            end
         endcase
      end
   end
endmodule

// *** testbench/flash_cmd_engine_monitor.sv ***
// Concurrent checks on the flash command engine ports.
module flash_cmd_engine_monitor (
   // Clock and reset.
   input logic clk,
   input logic rst,
   // Serial pins.
   input logic chip_select_n,
   input logic serial_clock,
   input logic io0_in,
   input logic io0_out,
   input logic io0_oe,
   input logic io1_out,
   input logic io1_oe,
   // Protection setting.
   input logic [2:0] block_protect,
   input logic protect_complement,
   // Status flags.
   input logic write_in_progress,
   input logic write_enable_latch,
   // Array ports.
   input logic [19:0] mem_rd_addr,
   input logic [7:0] mem_rd_data,
   input logic mem_wr_en,
   input logic [19:0] mem_wr_addr,
   input logic [7:0] mem_wr_data,
   input logic mem_clear_en,
   input logic [19:0] mem_clear_addr,
   input logic [1:0] mem_clear_kind
);
   // All checks run on the system clock and rest during reset.
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // Busy rises with the latch already gone and stays up for a while.
   property p_busy_start;
      $rose(write_in_progress) |-> !write_enable_latch ##0 write_in_progress [*8];
   endproperty
   a_busy_start: assert property (p_busy_start) else $error("busy start wrong");
   // A timed cycle only begins once select is seen high.
   property p_busy_cs;
      $rose(write_in_progress) |-> $past(chip_select_n);
   endproperty
   a_busy_cs: assert property (p_busy_cs) else $error("busy without select rise");
   // A clear needs the latch set just before it starts.
   property p_clear_wel;
      mem_clear_en |-> $past(write_enable_latch);
   endproperty
   a_clear_wel: assert property (p_clear_wel) else $error("clear without latch");
   // A clear never starts on top of a running cycle.
   property p_clear_idle;
      mem_clear_en |-> !$past(write_in_progress) && write_in_progress;
   endproperty
   a_clear_idle: assert property (p_clear_idle) else $error("clear while busy");
   // Sector clears cover a whole aligned 4 KB sector.
   property p_sector_align;
      mem_clear_en && mem_clear_kind == 2'h0 |-> mem_clear_addr[11:0] == 12'h000;
   endproperty
   a_sector_align: assert property (p_sector_align) else $error("sector base wrong");
   // Half block clears cover a whole aligned 32 KB block.
   property p_half_align;
      mem_clear_en && mem_clear_kind == 2'h1 |-> mem_clear_addr[14:0] == 15'h0000;
   endproperty
   a_half_align: assert property (p_half_align) else $error("half block base wrong");
   // Full block clears cover a whole aligned 64 KB block.
   property p_full_align;
      mem_clear_en && mem_clear_kind == 2'h2 |-> mem_clear_addr[15:0] == 16'h0000;
   endproperty
   a_full_align: assert property (p_full_align) else $error("full block base wrong");
   // Chip clear runs only with no block protected: bits all off, or all on with complement.
   property p_chip_prot;
      mem_clear_en && mem_clear_kind == 2'h3 |->
         (block_protect == 3'h0 && !protect_complement) ||
         (block_protect == 3'h7 && protect_complement);
   endproperty
   a_chip_prot: assert property (p_chip_prot) else $error("chip clear while protected");
   // Array writes happen only inside a program cycle.
   property p_wr_busy;
      mem_wr_en |-> write_in_progress && !write_enable_latch;
   endproperty
   a_wr_busy: assert property (p_wr_busy) else $error("write outside cycle");
endmodule

// *** testbench/spi_host_model.sv ***
// Host model that frames commands on the serial pins, mode 0.
module spi_host_model (
   // Clock.
   input logic clk,
   // Pins toward the device.
   output logic chip_select_n,
   output logic serial_clock,
   output logic host_io0,
   // Wire levels of the data lines.
   input logic io0_wire,
   input logic io1_wire
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      chip_select_n = 1'b1;
      serial_clock = 1'b0;
      host_io0 = 1'b0;
   end

   // Data byte pattern; bit 8 of the index changes it so late bytes differ.
   function automatic logic [7:0] pat(input int k);
      return k[7:0] ^ (k[8] ? 8'hAA : 8'h00);
   endfunction

   // One frame: header, data bytes, stray bits, then read units sampled late.
   task automatic frame(input logic [39:0] hdr, input int hb, input int nd, input int ex,
                        input int nrd, input bit dual, output logic [15:0] rd);
      int i, send;
      logic [7:0] d;
      send = hb + nd * 8 + ex;
      rd = 16'h0000;
      @(posedge clk);
      chip_select_n <= 1'b0;
      repeat (4) @(posedge clk);
      for (i = 0; i <= send + nrd; i++) begin
         if (i > send)
            rd = dual ? {rd[13:0], io1_wire, io0_wire} : {rd[14:0], io1_wire};
         if (i == send + nrd)
            break;
         serial_clock <= 1'b0;
         d = pat((i - hb) / 8);
         if (i < hb)
            host_io0 <= hdr[39 - i];
         else if (i < hb + nd * 8)
            host_io0 <= d[7 - (i - hb) % 8];
         else
            host_io0 <= ~host_io0;
         repeat (4) @(posedge clk);
         serial_clock <= 1'b1;
         repeat (4) @(posedge clk);
      end
      serial_clock <= 1'b0;
      repeat (4) @(posedge clk);
      chip_select_n <= 1'b1;
      repeat (10) @(posedge clk);
   endtask
endmodule

// *** testbench/serial_flash_program_erase_cmds_tb.sv ***
// Top bench for the flash command engine with host model, array model and checker.
module serial_flash_program_erase_cmds_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] MID = 8'hA5, DID = 8'h5A; // Arbitrary codes, the engine's defaults.
   typedef struct {logic [7:0] op; logic [23:0] a; logic [2:0] bp; logic cmp; logic run;
      logic [1:0] kind; logic [19:0] base;} row_t;
   logic clk, rst, chip_select_n, serial_clock, host_io0, io0_out, io0_oe, io1_out, io1_oe;
   logic protect_complement, write_in_progress, write_enable_latch, mem_wr_en, mem_clear_en;
   logic [2:0] block_protect;
   logic [19:0] mem_rd_addr, mem_wr_addr, mem_clear_addr, clr_base;
   logic [7:0] mem_rd_data, mem_wr_data;
   logic [1:0] mem_clear_kind, clr_kind;
   logic [15:0] r;
   logic [7:0] mem [0:20'hFFFFF];
   int checked, fail_count, clr_n, wr_n, n0, w0;
   wire io0_w = io0_oe ? io0_out : host_io0;
   wire io1_w = io1_oe ? io1_out : 1'bz;
   row_t rows[9] = '{
      '{8'h20, 24'h012345, 3'h0, 1'b0, 1'b1, 2'h0, 20'h12000},
      '{8'h52, 24'h0ABCDE, 3'h0, 1'b0, 1'b1, 2'h1, 20'hA8000},
      '{8'hD8, 24'h0ABCDE, 3'h0, 1'b0, 1'b1, 2'h2, 20'hA0000},
      '{8'h60, 24'h000000, 3'h0, 1'b0, 1'b1, 2'h3, 20'h00000},
      '{8'hC7, 24'h000000, 3'h7, 1'b1, 1'b1, 2'h3, 20'h00000},
      '{8'h60, 24'h000000, 3'h1, 1'b0, 1'b0, 2'h3, 20'h00000},
      '{8'h20, 24'h0F1000, 3'h1, 1'b0, 1'b0, 2'h0, 20'h00000},
      '{8'hD8, 24'h0E0000, 3'h2, 1'b0, 1'b0, 2'h2, 20'h00000},
      '{8'h52, 24'h0D8000, 3'h2, 1'b0, 1'b1, 2'h1, 20'hD8000}};

   flash_cmd_engine #(.PROG_CYCLES(32'h000003E8),
      .SECTOR_CYCLES(32'h00000190), .HALF_BLOCK_CYCLES(32'h00000190),
      .FULL_BLOCK_CYCLES(32'h00000190), .CHIP_CYCLES(32'h00000190)) i_dut (
      .clk(clk), .rst(rst), .chip_select_n(chip_select_n), .serial_clock(serial_clock),
      .io0_in(io0_w), .io0_out(io0_out), .io0_oe(io0_oe), .io1_out(io1_out), .io1_oe(io1_oe),
      .block_protect(block_protect), .protect_complement(protect_complement),
      .write_in_progress(write_in_progress), .write_enable_latch(write_enable_latch),
      .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data), .mem_wr_en(mem_wr_en),
      .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .mem_clear_en(mem_clear_en),
      .mem_clear_addr(mem_clear_addr), .mem_clear_kind(mem_clear_kind));
   spi_host_model i_host (.clk(clk), .chip_select_n(chip_select_n),
      .serial_clock(serial_clock), .host_io0(host_io0), .io0_wire(io0_w), .io1_wire(io1_w));

   // Array model: read data one clk late, byte writes, clears fill with FF.
   always @(posedge clk) begin
      mem_rd_data <= mem[mem_rd_addr];
      if (mem_wr_en) begin
         mem[mem_wr_addr] = mem_wr_data;
         wr_n++;
      end
      if (mem_clear_en) begin
         clr_n++;
         clr_kind <= mem_clear_kind;
         clr_base <= mem_clear_addr;
         for (int a = 0; a < (32'h1000 << 4'(16'h8430 >> (mem_clear_kind * 4))); a++)
            mem[mem_clear_addr + a[19:0]] = 8'hFF;
      end
   end

   // Compares one value and counts it.
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Frames a command with no read phase.
   task automatic cmd(input logic [39:0] h, input int hb, input int nd = 0, input int ex = 0);
      i_host.frame(h, hb, nd, ex, 0, 1'b0, r);
   endtask

   // Waits for the timed cycle to end under a bound.
   task automatic wait_idle;
      int n = 0;
      while (write_in_progress !== 1'b0 && n < 5000) begin
         @(posedge clk);
         n++;
      end
      check("idle", 16'(n < 5000), 16'h0001);
   endtask

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   initial begin
      #1500us;
      fail_count++;
      report_and_stop();
   end

   initial begin
      rst = 1'b1;
      block_protect = 3'h0;
      protect_complement = 1'b0;
      mem_rd_data = 8'h00;
      for (int a = 0; a < 32'h100000; a++)
         mem[a] = 8'hFF;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (5) @(posedge clk);
      check("reset", 16'({write_in_progress, write_enable_latch, io0_oe, io1_oe}), 16'h0000);
      // Clear without the latch and badly framed clears do nothing.
      cmd({8'h20, 24'h001000, 8'h00}, 32);
      check("no latch", 16'({clr_n[3:0], write_in_progress}), 16'h0000);
      cmd({8'h06, 32'h0}, 8);
      i_host.frame({8'h05, 32'h0}, 8, 0, 0, 8, 1'b0, r);
      check("status", r, 16'h0002);
      cmd({8'h20, 24'h001000, 8'h00}, 33);
      cmd({8'h60, 32'h0}, 9);
      check("framing", 16'({clr_n[3:0], write_in_progress, write_enable_latch}), 16'h0001);
      cmd({8'h04, 32'h0}, 8);
      check("wrdi", 16'(write_enable_latch), 16'h0000);
      // Clear table: kinds, bases and protection.
      foreach (rows[i]) begin
         block_protect <= rows[i].bp;
         protect_complement <= rows[i].cmp;
         n0 = clr_n;
         cmd({8'h06, 32'h0}, 8);
         cmd({rows[i].op, rows[i].a, 8'h00}, rows[i].kind == 2'h3 && rows[i].op != 8'h20 ? 8 : 32);
         check("clear run", 16'({clr_n - n0, write_in_progress}), 16'({rows[i].run, rows[i].run}));
         if (rows[i].run)
            check("clear", 16'({clr_kind, clr_base[19:12]}),
               16'({rows[i].kind, rows[i].base[19:12]}));
         wait_idle();
      end
      block_protect <= 3'h0;
      protect_complement <= 1'b0;
      // Wrapping program, busy polling and commands refused while busy.
      cmd({8'h06, 32'h0}, 8);
      cmd({8'h02, 24'h0300F0, 8'h00}, 32, 20);
      i_host.frame({8'h05, 32'h0}, 8, 0, 0, 8, 1'b0, r);
      check("busy status", r, 16'h0001);
      n0 = clr_n;
      cmd({8'h06, 32'h0}, 8);
      cmd({8'h20, 24'h030000, 8'h00}, 32);
      wait_idle();
      check("busy refuse", 16'({clr_n - n0, write_enable_latch}), 16'h0000);
      for (int k = 0; k < 20; k++)
         check("wrap", 16'(mem[20'h30000 + ((20'hF0 + k) & 20'hFF)]), 16'(i_host.pat(k)));
      check("untouched", 16'({mem[20'h30004], mem[20'h300EF]}), 16'hFFFF);
      // Over 256 bytes keeps the last 256.
      cmd({8'h06, 32'h0}, 8);
      cmd({8'h02, 24'h040000, 8'h00}, 32, 260);
      wait_idle();
      for (int k = 0; k < 256; k++)
         check("last 256", 16'(mem[20'h40000 + k]), 16'(i_host.pat(k < 4 ? k + 256 : k)));
      // Program ended mid-byte, then program into a protected page.
      w0 = wr_n;
      cmd({8'h06, 32'h0}, 8);
      cmd({8'h02, 24'h050000, 8'h00}, 32, 1, 4);
      check("mid byte", 16'({wr_n - w0, write_in_progress}), 16'h0000);
      block_protect <= 3'h1;
      cmd({8'h02, 24'h0F0000, 8'h00}, 32, 1);
      check("protected", 16'({wr_n - w0, write_in_progress}), 16'h0000);
      block_protect <= 3'h0;
      // Dual read across bytes and the id read.
      i_host.frame({8'h3B, 24'h0300FE, 8'h00}, 40, 0, 0, 8, 1'b1, r);
      check("dual", r, {i_host.pat(14), i_host.pat(15)});
      i_host.frame({8'h90, 32'h0}, 32, 0, 0, 16, 1'b0, r);
      check("id", r, {MID, DID});
      report_and_stop();
   end
endmodule

bind flash_cmd_engine flash_cmd_engine_monitor i_mon (.clk(clk), .rst(rst),
   .chip_select_n(chip_select_n), .serial_clock(serial_clock), .io0_in(io0_in),
   .io0_out(io0_out), .io0_oe(io0_oe), .io1_out(io1_out), .io1_oe(io1_oe),
   .block_protect(block_protect), .protect_complement(protect_complement),
   .write_in_progress(write_in_progress), .write_enable_latch(write_enable_latch),
   .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data), .mem_wr_en(mem_wr_en),
   .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .mem_clear_en(mem_clear_en),
   .mem_clear_addr(mem_clear_addr), .mem_clear_kind(mem_clear_kind));
